// File: shared/serdes_pll_pkg.sv
// Constants, register map and decode functions for the SerDes PLL rate configuration block.
// Function
// - PLL runs only after software sets enable.
// - Enable zero powers PLL fully down.
// - Multiplier codes select ten, twenty, twenty-five.
// - Rate codes: full, half, quarter, reserved.
// - Transmit and receive rates set independently.
// - Byte clock is PLL divided 5/10/20.
// - Line rate is PLL times 2/1/0.5.
package serdes_pll_pkg;

  // Register bus.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PLL_CFG_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] TX_CFG_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] RX_CFG_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'hc;

  // Field positions.
  localparam int ENABLE_BIT = 0;
  localparam int MULT_LSB = 1;
  localparam int MULT_MSB = 4;
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 1;
  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_SETTLING_BIT = 1;
  localparam int ST_STABLE_BIT = 2;
  localparam int ST_MULT_RSVD_BIT = 3;
  localparam int ST_TX_VALID_BIT = 4;
  localparam int ST_RX_VALID_BIT = 5;
  localparam int ST_FACTOR_LSB = 8;
  localparam int ST_FACTOR_MSB = 12;

  // Reset values.
  localparam logic RESET_ENABLE = 1'b0;
  localparam logic [3:0] RESET_MULT = 4'h5;
  localparam logic [1:0] RESET_RATE = 2'h1;

  // Encodings.
  localparam logic [3:0] MULT_X10 = 4'h5;
  localparam logic [3:0] MULT_X20 = 4'h9;
  localparam logic [3:0] MULT_X25 = 4'ha;
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [4:0] FACTOR_10 = 5'd10;
  localparam logic [4:0] FACTOR_20 = 5'd20;
  localparam logic [4:0] FACTOR_25 = 5'd25;
  localparam logic [4:0] DIV_FULL = 5'd5;
  localparam logic [4:0] DIV_HALF = 5'd10;
  localparam logic [4:0] DIV_QUARTER = 5'd20;
  // Line rate as twice the PLL multiple, so that 0.5 is exact.
  localparam logic [2:0] LINE_X2_FULL = 3'd4;
  localparam logic [2:0] LINE_X2_HALF = 3'd2;
  localparam logic [2:0] LINE_X2_QUARTER = 3'd1;

  // Settling time: the reference clock is clock_i.
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_REF_CYCLES = 200;
  localparam int SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SETTLE_REF_CYCLES;
  localparam int COUNT_W = 9;
  localparam logic [COUNT_W-1:0] SETTLE_LAST = COUNT_W'(SETTLE_CYCLES - 1);

  function automatic logic [4:0] mult_factor(input logic [3:0] sel);
    logic [4:0] f;
    f = 5'd0;
    case (sel)
      MULT_X10: f = FACTOR_10;
      MULT_X20: f = FACTOR_20;
      MULT_X25: f = FACTOR_25;
      default: f = 5'd0;
    endcase
    return f;
  endfunction

  function automatic logic [4:0] byte_divider(input logic [1:0] rate);
    logic [4:0] d;
    d = 5'd0;
    case (rate)
      RATE_FULL: d = DIV_FULL;
      RATE_HALF: d = DIV_HALF;
      RATE_QUARTER: d = DIV_QUARTER;
      default: d = 5'd0;
    endcase
    return d;
  endfunction

  function automatic logic [2:0] line_multiple_x2(input logic [1:0] rate);
    logic [2:0] m;
    m = 3'd0;
    case (rate)
      RATE_FULL: m = LINE_X2_FULL;
      RATE_HALF: m = LINE_X2_HALF;
      RATE_QUARTER: m = LINE_X2_QUARTER;
      default: m = 3'd0;
    endcase
    return m;
  endfunction

endpackage

// File: rtl/serdes_pll_rate_config.sv
// SerDes PLL enable, multiplier and per-direction rate configuration with settling tracking.
`timescale 1ns/1ps
module serdes_pll_rate_config
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [serdes_pll_pkg::ADDR_W-1:0] address_i,
  input wire logic [serdes_pll_pkg::DATA_W-1:0] write_data_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [serdes_pll_pkg::DATA_W-1:0] read_data_o,
  // PLL control.
  output logic pll_enable_o,
  output logic [4:0] pll_factor_o,
  output logic pll_stable_o,
  // Transmit and receive derivation.
  output logic [4:0] tx_byte_div_o,
  output logic [4:0] rx_byte_div_o,
  output logic [2:0] tx_line_x2_o,
  output logic [2:0] rx_line_x2_o,
  output logic tx_byte_clock_valid_o,
  output logic rx_byte_clock_valid_o
);
  import serdes_pll_pkg::*;

  typedef enum logic [2:0]
  {
    PLL_OFF = 3'b001,
    PLL_SETTLE = 3'b010,
    PLL_LOCKED = 3'b100
  } pll_state_e;

  typedef struct packed {
    pll_state_e state;
    logic [COUNT_W-1:0] settle_count;
    logic power_enable;
    logic [3:0] mult_sel;
    logic [1:0] tx_rate;
    logic [1:0] rx_rate;
    logic [DATA_W-1:0] read_data;
    logic [4:0] factor;
    logic [4:0] tx_div;
    logic [4:0] rx_div;
    logic [2:0] tx_line;
    logic [2:0] rx_line;
    logic stable;
  } regs_s;

  regs_s r;
  regs_s next_r;
  logic pll_write;
  logic tx_write;
  logic rx_write;
  logic [DATA_W-1:0] status_word;

  assign pll_write = write_i && (address_i == PLL_CFG_OFFSET);
  assign tx_write = write_i && (address_i == TX_CFG_OFFSET);
  assign rx_write = write_i && (address_i == RX_CFG_OFFSET);

  always_comb
  begin
    status_word = '0;
    status_word[ST_ENABLED_BIT] = r.power_enable;
    status_word[ST_SETTLING_BIT] = (r.state == PLL_SETTLE);
    status_word[ST_STABLE_BIT] = r.stable;
    status_word[ST_MULT_RSVD_BIT] = (mult_factor(r.mult_sel) == 5'd0);
    status_word[ST_TX_VALID_BIT] = tx_byte_clock_valid_o;
    status_word[ST_RX_VALID_BIT] = rx_byte_clock_valid_o;
    status_word[ST_FACTOR_MSB:ST_FACTOR_LSB] = r.factor;
  end

  always_comb
  begin
    next_r = r;
    // Software writes steer the PLL and the two independent rate fields.
    if (pll_write)
    begin
      next_r.power_enable = write_data_i[ENABLE_BIT];
      next_r.mult_sel = write_data_i[MULT_MSB:MULT_LSB];
    end
    if (tx_write)
    begin
      next_r.tx_rate = write_data_i[RATE_MSB:RATE_LSB];
    end
    if (rx_write)
    begin
      next_r.rx_rate = write_data_i[RATE_MSB:RATE_LSB];
    end

    // A new multiplier on a running PLL forces it to settle again.
    case (r.state)
      PLL_OFF:
      begin
        next_r.settle_count = '0;
        if (next_r.power_enable)
        begin
          next_r.state = PLL_SETTLE;
        end
      end
      PLL_SETTLE:
      begin
        next_r.settle_count = r.settle_count + COUNT_W'(1);
        if (r.settle_count == SETTLE_LAST)
        begin
          next_r.state = PLL_LOCKED;
        end
      end
      PLL_LOCKED:
      begin
        next_r.settle_count = '0;
      end
      default:
      begin
        next_r.state = PLL_OFF;
        next_r.settle_count = '0;
      end
    endcase
    if (r.state != PLL_OFF && next_r.power_enable && next_r.mult_sel != r.mult_sel)
    begin
      next_r.state = PLL_SETTLE;
      next_r.settle_count = '0;
    end
    if (!next_r.power_enable)
    begin
      next_r.state = PLL_OFF;
      next_r.settle_count = '0;
    end

    // The PLL produces nothing while powered down.
    next_r.factor = next_r.power_enable ? mult_factor(next_r.mult_sel) : 5'd0;
    next_r.stable = (next_r.state == PLL_LOCKED);
    next_r.tx_div = byte_divider(next_r.tx_rate);
    next_r.rx_div = byte_divider(next_r.rx_rate);
    next_r.tx_line = line_multiple_x2(next_r.tx_rate);
    next_r.rx_line = line_multiple_x2(next_r.rx_rate);

    // Read data stands only in the cycle after the strobe.
    next_r.read_data = '0;
    if (read_i)
    begin
      case (address_i)
        PLL_CFG_OFFSET:
        begin
          next_r.read_data[ENABLE_BIT] = r.power_enable;
          next_r.read_data[MULT_MSB:MULT_LSB] = r.mult_sel;
        end
        TX_CFG_OFFSET: next_r.read_data[RATE_MSB:RATE_LSB] = r.tx_rate;
        RX_CFG_OFFSET: next_r.read_data[RATE_MSB:RATE_LSB] = r.rx_rate;
        STATUS_OFFSET: next_r.read_data = status_word;
        default: next_r.read_data = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r.state <= PLL_OFF;
      r.settle_count <= '0;
      r.power_enable <= RESET_ENABLE;
      r.mult_sel <= RESET_MULT;
      r.tx_rate <= RESET_RATE;
      r.rx_rate <= RESET_RATE;
      r.read_data <= '0;
      r.factor <= 5'd0;
      r.tx_div <= DIV_HALF;
      r.rx_div <= DIV_HALF;
      r.tx_line <= LINE_X2_HALF;
      r.rx_line <= LINE_X2_HALF;
      r.stable <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign read_data_o = r.read_data;
  assign pll_enable_o = r.power_enable;
  assign pll_factor_o = r.factor;
  assign pll_stable_o = r.stable;
  assign tx_byte_div_o = r.tx_div;
  assign rx_byte_div_o = r.rx_div;
  assign tx_line_x2_o = r.tx_line;
  assign rx_line_x2_o = r.rx_line;
  // Downstream byte logic stays idle until settled and configured legally.
  assign tx_byte_clock_valid_o = r.stable && (r.factor != 5'd0) && (r.tx_div != 5'd0);
  assign rx_byte_clock_valid_o = r.stable && (r.factor != 5'd0) && (r.rx_div != 5'd0);

  pll_enable_write_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    pll_write |=> (pll_enable_o == $past(write_data_i[ENABLE_BIT])))
    else $error("PLL enable does not follow the written bit");

  power_down_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !pll_enable_o |-> (pll_factor_o == 5'd0) && !pll_stable_o && !tx_byte_clock_valid_o
      && !rx_byte_clock_valid_o)
    else $error("Powered-down PLL still shows an output");

  factor_map_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    pll_enable_o |->
      (r.mult_sel == MULT_X10) ? (pll_factor_o == 5'd10) :
      (r.mult_sel == MULT_X20) ? (pll_factor_o == 5'd20) :
      (r.mult_sel == MULT_X25) ? (pll_factor_o == 5'd25) : (pll_factor_o == 5'd0))
    else $error("Multiplier factor does not match its code");

  reserved_rate_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (r.tx_rate == 2'h3) |-> (tx_byte_div_o == 5'd0) && !tx_byte_clock_valid_o)
    else $error("Reserved transmit rate gives a byte clock");

  rate_separate_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (tx_write && !rx_write) |=> $stable(rx_byte_div_o) && $stable(rx_line_x2_o))
    else $error("Transmit rate write disturbed receive rate");

  byte_divider_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    rx_write |=>
      ($past(write_data_i[1:0]) == 2'h0) ? (rx_byte_div_o == 5'd5) :
      ($past(write_data_i[1:0]) == 2'h1) ? (rx_byte_div_o == 5'd10) :
      ($past(write_data_i[1:0]) == 2'h2) ? (rx_byte_div_o == 5'd20) : (rx_byte_div_o == 5'd0))
    else $error("Receive byte divider wrong for the written rate");

  line_rate_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (tx_byte_div_o != 5'd0) |-> (32'(tx_byte_div_o) * 32'(tx_line_x2_o) == 32'd20))
    else $error("Line rate and byte divider disagree");

  settle_hold_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(pll_enable_o) |-> !pll_stable_o [*8])
    else $error("PLL reported stable too early after enable");

  settle_count_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $rose(pll_stable_o) |-> $past(r.settle_count) == 9'd249)
    else $error("Stable reported without the full settling count");

  read_once_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !$past(read_i) |-> (read_data_o == '0))
    else $error("Read data present without a read strobe");

  enable_start_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (pll_write && write_data_i[ENABLE_BIT] && (r.state == PLL_OFF)) |=> (r.state == PLL_SETTLE))
    else $error("Enabling the PLL did not start the settling wait");

  state_onehot_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    $onehot(r.state) && ((r.state == PLL_OFF) == !pll_enable_o))
    else $error("PLL state and power enable disagree");

  disable_drop_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (pll_write && !write_data_i[ENABLE_BIT]) |=> !pll_stable_o && (r.state == PLL_OFF))
    else $error("Clearing the enable did not power the PLL down");

  settle_bound_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (r.state == PLL_SETTLE) |-> (r.settle_count <= SETTLE_LAST))
    else $error("Settling counter ran past its last value");

  relock_wait_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (pll_write && write_data_i[ENABLE_BIT] && pll_enable_o
      && (write_data_i[MULT_MSB:MULT_LSB] != r.mult_sel))
      |=> !pll_stable_o && (r.settle_count == '0))
    else $error("New multiplier did not restart the settling wait");

  tx_divider_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    tx_write |=>
      ($past(write_data_i[1:0]) == RATE_FULL) ? (tx_byte_div_o == DIV_FULL) :
      ($past(write_data_i[1:0]) == RATE_HALF) ? (tx_byte_div_o == DIV_HALF) :
      ($past(write_data_i[1:0]) == RATE_QUARTER) ? (tx_byte_div_o == DIV_QUARTER) :
      (tx_byte_div_o == 5'h0))
    else $error("Transmit byte divider wrong for the written rate");

  full_line_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (tx_write && (write_data_i[1:0] == RATE_FULL)) |=> (tx_line_x2_o == LINE_X2_FULL))
    else $error("Full rate does not double the transmit line rate");

  quarter_line_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (rx_write && (write_data_i[1:0] == RATE_QUARTER)) |=> (rx_line_x2_o == LINE_X2_QUARTER))
    else $error("Quarter rate does not halve the receive line rate");

  rx_reserved_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (r.rx_rate == 2'h3) |-> (rx_byte_div_o == 5'h0) && (rx_line_x2_o == 3'h0) && !rx_byte_clock_valid_o)
    else $error("Reserved receive rate gives a byte clock");

  rx_separate_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (rx_write && !tx_write) |=> $stable(tx_byte_div_o) && $stable(tx_line_x2_o))
    else $error("Receive rate write disturbed transmit rate");

  valid_gate_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (tx_byte_clock_valid_o || rx_byte_clock_valid_o) |-> pll_stable_o && (r.state == PLL_LOCKED))
    else $error("Byte clock marked valid before the PLL settled");

  read_config_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (read_i && (address_i == PLL_CFG_OFFSET)) |=> (read_data_o[ENABLE_BIT] == $past(pll_enable_o))
      && (read_data_o[MULT_MSB:MULT_LSB] == $past(r.mult_sel)))
    else $error("Configuration read does not show the stored fields");

  status_stable_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (read_i && (address_i == STATUS_OFFSET))
      |=> (read_data_o[ST_STABLE_BIT] == $past(pll_stable_o))
      && (read_data_o[ST_ENABLED_BIT] == $past(pll_enable_o)))
    else $error("Status read does not show enable and stable");

endmodule

// File: bench/serdes_pll_rate_config_test.sv
// Self-checking bench for the SerDes PLL rate configuration block.
`timescale 1ns/1ps
module serdes_pll_rate_config_test;
  import serdes_pll_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] address_i = '0;
  logic [DATA_W-1:0] write_data_i = '0;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic [DATA_W-1:0] read_data_o;
  logic pll_enable_o, pll_stable_o, tx_byte_clock_valid_o, rx_byte_clock_valid_o;
  logic [4:0] pll_factor_o, tx_byte_div_o, rx_byte_div_o;
  logic [2:0] tx_line_x2_o, rx_line_x2_o;
  int n_fail = 0;
  int cmp_count = 0;
  int en = 0, mult = 5, tx = 1, rx = 1, stab = 0;

  always #10 clock_i = ~clock_i;

  serdes_pll_rate_config dut_u (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
    .write_data_i(write_data_i), .write_i(write_i), .read_i(read_i),
    .read_data_o(read_data_o), .pll_enable_o(pll_enable_o), .pll_factor_o(pll_factor_o),
    .pll_stable_o(pll_stable_o), .tx_byte_div_o(tx_byte_div_o),
    .rx_byte_div_o(rx_byte_div_o), .tx_line_x2_o(tx_line_x2_o),
    .rx_line_x2_o(rx_line_x2_o), .tx_byte_clock_valid_o(tx_byte_clock_valid_o),
    .rx_byte_clock_valid_o(rx_byte_clock_valid_o));

  function automatic int fac(input int m);
    return (m == 5) ? 10 : (m == 9) ? 20 : (m == 10) ? 25 : 0;
  endfunction
  function automatic int dv(input int r);
    return (r == 0) ? 5 : (r == 1) ? 10 : (r == 2) ? 20 : 0;
  endfunction
  function automatic int lx(input int r);
    return (r == 0) ? 4 : (r == 1) ? 2 : (r == 2) ? 1 : 0;
  endfunction
  function automatic int vld(input int r);
    return (stab != 0 && fac(mult) != 0 && dv(r) != 0) ? 1 : 0;
  endfunction
  function automatic int stat();
    return en + 2 * (en != 0 && stab == 0) + 4 * stab + 8 * (fac(mult) == 0) + 16 * vld(tx)
      + 32 * vld(rx) + 256 * ((en != 0) ? fac(mult) : 0);
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Each access leaves one idle cycle so no strobe is assigned twice in a time step.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    write_i <= 1'b1;
    address_i <= a;
    write_data_i <= d;
    @(posedge clock_i);
    write_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    read_i <= 1'b1;
    address_i <= a;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1;
    d = read_data_o;
  endtask

  task automatic chk_out();
    chk("enable", pll_enable_o, en);
    chk("factor", pll_factor_o, (en != 0) ? fac(mult) : 0);
    chk("stable", pll_stable_o, stab);
    chk("tx div", tx_byte_div_o, dv(tx));
    chk("rx div", rx_byte_div_o, dv(rx));
    chk("tx line", tx_line_x2_o, lx(tx));
    chk("rx line", rx_line_x2_o, lx(rx));
    chk("tx valid", tx_byte_clock_valid_o, vld(tx));
    chk("rx valid", rx_byte_clock_valid_o, vld(rx));
  endtask

  initial
  begin
    logic [31:0] d;
    int n;
    void'($urandom(32'h98d0));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk_out();
    rd(PLL_CFG_OFFSET, d);
    chk("cfg reset", d, 32'h0000000a);
    rd(STATUS_OFFSET, d);
    chk("status reset", d, stat());
    rd(4'h2, d);
    chk("unmapped read", d, 32'h0);
    @(posedge clock_i);
    #1;
    chk("read idle", read_data_o, 32'h0);
    // Every multiplier code, reserved ones included.
    for (int m = 0; m < 16; m++)
    begin
      en = 1;
      mult = m;
      d = $urandom();
      d[4:0] = {m[3:0], 1'b1};
      wr(PLL_CFG_OFFSET, d);
      chk_out();
      rd(PLL_CFG_OFFSET, d);
      chk("cfg", d, 2 * m + 1);
      rd(STATUS_OFFSET, d);
      chk("status", d, stat());
    end
    en = 0;
    wr(PLL_CFG_OFFSET, 32'h14);
    chk_out();
    en = 1;
    mult = 10;
    wr(PLL_CFG_OFFSET, 32'h15);
    chk_out();
    n = 0;
    while (pll_stable_o !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 400)
    begin
      n_fail++;
    end
    chk("settle cycles", n, 1000 / 20 + 200);
    stab = 1;
    chk_out();
    // The chosen settings match a 50 MHz reference to a 1250 Mbps line.
    chk("tx line rate", 32'(pll_factor_o) * 32'(tx_line_x2_o) * 25, 1250);
    chk("rx line rate", 32'(pll_factor_o) * 32'(rx_line_x2_o) * 25, 1250);
    for (int i = 0; i < 4; i++)
    begin
      tx = i;
      rx = 3 - i;
      d = $urandom();
      d[1:0] = tx[1:0];
      wr(TX_CFG_OFFSET, d);
      d = $urandom();
      d[1:0] = rx[1:0];
      wr(RX_CFG_OFFSET, d);
      chk_out();
      rd(TX_CFG_OFFSET, d);
      chk("tx cfg", d, tx);
      rd(RX_CFG_OFFSET, d);
      chk("rx cfg", d, rx);
      rd(STATUS_OFFSET, d);
      chk("status rate", d, stat());
    end
    wr(STATUS_OFFSET, 32'hffffffff);
    wr(4'h6, 32'hffffffff);
    chk_out();
    // A different multiplier on a locked PLL restarts the settling wait.
    mult = 9;
    stab = 0;
    wr(PLL_CFG_OFFSET, 32'h13);
    chk_out();
    rd(STATUS_OFFSET, d);
    chk("status relock", d, stat());
    // A reset in mid-run returns every output to its idle value.
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    en = 0;
    mult = 5;
    tx = 1;
    rx = 1;
    chk_out();
    chk("read reset", read_data_o, 32'h0);
    rd(PLL_CFG_OFFSET, d);
    chk("cfg after reset", d, 32'h0000000a);
    mult = 10;
    wr(PLL_CFG_OFFSET, 32'h14);
    chk_out();
    rd(STATUS_OFFSET, d);
    chk("status off", d, stat());
    print_verdict();
  end
endmodule
